// *** src/file_register_alu_ops.sv ***
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "alu_ops_cfg.svh"
module file_register_alu_ops
    import alu_ops_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // instruction issue from the decode stage
    input wire logic instr_valid,
    input op_t instr_op,
    input wire logic instr_dest,
    input wire logic [6:0] instr_addr,
    output logic instr_ready,
    // status events from the watchdog and sleep logic
    input wire logic timeout_event,
    input wire logic sleep_event,
    // control to fetch stage and watchdog
    output logic squash_next,
    output logic watchdog_clear,
    output logic prescaler_clear
);
    typedef struct packed {
        logic [127:0][7:0] file;
        logic [7:0] accumulator;
        logic z;
        logic c;
        logic dc;
        logic timeout_status_n;
        logic powerdown_status_n;
        logic ps_wdt;
        seq_t seq;
        logic squash;
        logic wdt_clr;
        logic ps_clr;
        logic ack;
        logic [7:0] rdata;
    } core_state_t;

    core_state_t st_reg;
    core_state_t st_next;
    alu_calc_if calc_bus ();
    logic bus_req;
    logic bus_wr;
    logic file_hit;
    logic accept;
    logic [7:0] operand;
    logic [7:0] status_view;

    // one clock domain; every check below is off while reset is low
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // ---------------------------------------------------------------
    // datapath
    // ---------------------------------------------------------------
    alu_calc alu_calc_inst (
        .bus(calc_bus)
    );

    assign operand = st_reg.file[instr_addr];
    assign calc_bus.op = instr_op;
    assign calc_bus.operand = operand;
    assign calc_bus.acc = st_reg.accumulator;
    assign calc_bus.c_in = st_reg.c;
    assign calc_bus.dc_in = st_reg.dc;

    assign bus_req = wb_cyc_i && wb_stb_i && !st_reg.ack;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    assign file_hit = wb_adr_i[`ADR_HI_MSB:`ADR_HI_LSB] == `FILE_BASE_HI;
    // a bus write stalls the core so both never touch state together
    assign instr_ready = (st_reg.seq == seq_exec) && !bus_wr;
    assign accept = instr_valid && instr_ready;

    always_comb begin
        status_view = 8'h00;
        status_view[`ST_Z_BIT] = st_reg.z;
        status_view[`ST_C_BIT] = st_reg.c;
        status_view[`ST_DC_BIT] = st_reg.dc;
        status_view[`ST_PD_BIT] = st_reg.powerdown_status_n;
        status_view[`ST_TO_BIT] = st_reg.timeout_status_n;
        status_view[`ST_PSW_BIT] = st_reg.ps_wdt;
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.squash = 1'b0;
        st_next.wdt_clr = 1'b0;
        st_next.ps_clr = 1'b0;
        st_next.ack = 1'b0;
        if (bus_req) begin
            st_next.ack = 1'b1;
            st_next.rdata = 8'h00;
            if (file_hit) begin
                st_next.rdata = st_reg.file[wb_adr_i[8:2]];
                if (bus_wr) begin
                    st_next.file[wb_adr_i[8:2]] = wb_dat_i[7:0];
                end
            end else if (wb_adr_i == `ACC_OFS) begin
                st_next.rdata = st_reg.accumulator;
                if (bus_wr) begin
                    st_next.accumulator = wb_dat_i[7:0];
                end
            end else if (wb_adr_i == `STATUS_OFS) begin
                st_next.rdata = status_view;
                if (bus_wr) begin
                    st_next.z = wb_dat_i[`ST_Z_BIT];
                    st_next.c = wb_dat_i[`ST_C_BIT];
                    st_next.dc = wb_dat_i[`ST_DC_BIT];
                    st_next.ps_wdt = wb_dat_i[`ST_PSW_BIT];
                end
            end
        end
        if (accept) begin
            if (calc_bus.z_upd) begin
                st_next.z = calc_bus.z_out;
            end
            if (calc_bus.c_upd) begin
                st_next.c = calc_bus.c_out;
            end
            case (instr_op)
                clear_register_op: begin
                    st_next.file[instr_addr] = calc_bus.result;
                end
                complement_register_op, decrement_skip_zero_op: begin
                    if (instr_dest) begin
                        st_next.file[instr_addr] = calc_bus.result;
                    end else begin
                        st_next.accumulator = calc_bus.result;
                    end
                    if (calc_bus.skip) begin
                        st_next.squash = 1'b1;
                        st_next.seq = seq_squash;
                    end
                end
                watchdog_clear_op: begin
                    st_next.wdt_clr = 1'b1;
                    st_next.ps_clr = st_reg.ps_wdt;
                    st_next.timeout_status_n = 1'b1;
                    st_next.powerdown_status_n = 1'b1;
                end
                decimal_adjust_op: begin
                    st_next.accumulator = calc_bus.result;
                end
                default: begin
                    // compare leaves every operand in place
                    st_next.seq = seq_exec;
                end
            endcase
        end else if (st_reg.seq == seq_squash) begin
            st_next.seq = seq_exec;
        end
        // hardware events win over a clear in the same cycle
        if (timeout_event) begin
            st_next.timeout_status_n = 1'b0;
        end
        if (sleep_event) begin
            st_next.powerdown_status_n = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg.file <= {128{`FILE_RST}};
            st_reg.accumulator <= `ACC_RST;
            st_reg.z <= 1'b0;
            st_reg.c <= 1'b0;
            st_reg.dc <= 1'b0;
            st_reg.timeout_status_n <= `TO_N_RST;
            st_reg.powerdown_status_n <= `PD_N_RST;
            st_reg.ps_wdt <= `PS_WDT_RST;
            st_reg.seq <= seq_exec;
            st_reg.squash <= 1'b0;
            st_reg.wdt_clr <= 1'b0;
            st_reg.ps_clr <= 1'b0;
            st_reg.ack <= 1'b0;
            st_reg.rdata <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o = {24'h000000, st_reg.rdata};
    assign wb_ack_o = st_reg.ack;
    assign squash_next = st_reg.squash;
    assign watchdog_clear = st_reg.wdt_clr;
    assign prescaler_clear = st_reg.ps_clr;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_clear_result: assert property (
        accept && instr_op == clear_register_op
        |=> st_reg.file[$past(instr_addr)] == 8'h00 && st_reg.z)
        else $error("clear did not zero register and set zero flag");

    chk_comp_to_acc: assert property (
        accept && instr_op == complement_register_op && !instr_dest
        |=> st_reg.accumulator == ~$past(operand) && st_reg.z == (st_reg.accumulator == 8'h00))
        else $error("complement to accumulator wrong");

    chk_comp_to_reg: assert property (
        accept && instr_op == complement_register_op && instr_dest
        |=> st_reg.file[$past(instr_addr)] == ~$past(operand)
            && st_reg.accumulator == $past(st_reg.accumulator))
        else $error("complement to register wrong");

    chk_wdt_pulses: assert property (
        accept && instr_op == watchdog_clear_op
        |=> watchdog_clear && prescaler_clear == $past(st_reg.ps_wdt)
            ##1 (!watchdog_clear || $past(accept && instr_op == watchdog_clear_op)))
        else $error("watchdog clear pulses wrong");

    chk_wdt_status: assert property (
        accept && instr_op == watchdog_clear_op && !timeout_event && !sleep_event
        |=> st_reg.timeout_status_n && st_reg.powerdown_status_n)
        else $error("status bits not set by watchdog clear");

    chk_compare_flags: assert property (
        accept && instr_op == compare_acc_register_op
        |=> st_reg.c == ($past(operand) >= $past(st_reg.accumulator))
            && st_reg.z == ($past(operand) == $past(st_reg.accumulator)))
        else $error("compare flags wrong");

    chk_compare_keep: assert property (
        accept && instr_op == compare_acc_register_op
        |=> st_reg.accumulator == $past(st_reg.accumulator) && st_reg.file == $past(st_reg.file))
        else $error("compare modified an operand");

    chk_daa_zero_kept: assert property (
        accept && instr_op == decimal_adjust_op |=> st_reg.z == $past(st_reg.z))
        else $error("decimal adjust touched zero flag");

    chk_decr_skip: assert property (
        accept && instr_op == decrement_skip_zero_op && operand == 8'h01
        |=> squash_next && !instr_ready ##1 !squash_next && st_reg.seq == seq_exec)
        else $error("decrement to zero did not squash for one cycle");

    chk_decr_noskip: assert property (
        accept && instr_op == decrement_skip_zero_op && operand != 8'h01 && !instr_dest
        |=> !squash_next && st_reg.accumulator == $past(operand) - 8'h01)
        else $error("decrement result or skip wrong");

    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held longer than one cycle");

    chk_clear_keep_acc: assert property (
        accept && instr_op == clear_register_op
        |=> st_reg.accumulator == $past(st_reg.accumulator) && st_reg.c == $past(st_reg.c))
        else $error("clear touched accumulator or carry");

    chk_decr_to_reg: assert property (
        accept && instr_op == decrement_skip_zero_op && instr_dest
        |=> st_reg.file[$past(instr_addr)] == $past(operand) - 8'h01
            && st_reg.accumulator == $past(st_reg.accumulator))
        else $error("decrement to register wrong");

    // the skip alone tells the program about zero; the flag stays
    chk_decr_zero_kept: assert property (
        accept && instr_op == decrement_skip_zero_op |=> st_reg.z == $past(st_reg.z))
        else $error("decrement touched zero flag");

    // a value already in packed decimal with no carries in passes through
    chk_daa_bcd_kept: assert property (
        accept && instr_op == decimal_adjust_op && !st_reg.c && !st_reg.dc
            && st_reg.accumulator[7:4] <= `NIBBLE_MAX && st_reg.accumulator[3:0] <= `NIBBLE_MAX
        |=> st_reg.accumulator == $past(st_reg.accumulator) && !st_reg.c)
        else $error("decimal adjust changed a packed decimal value");

    chk_daa_low_fix: assert property (
        accept && instr_op == decimal_adjust_op && !st_reg.c && st_reg.dc
            && st_reg.accumulator[7:4] <= `NIBBLE_MAX && st_reg.accumulator[3:0] <= `NIBBLE_MAX
        |=> st_reg.accumulator == $past(st_reg.accumulator) + 8'h06 && !st_reg.c)
        else $error("decimal adjust low correction wrong");

    // a hardware event outranks a watchdog clear in the same cycle
    chk_timeout_wins: assert property (
        timeout_event |=> !st_reg.timeout_status_n)
        else $error("time-out event lost");

    chk_sleep_wins: assert property (
        sleep_event |=> !st_reg.powerdown_status_n)
        else $error("sleep event lost");

    chk_squash_single: assert property (
        squash_next |=> !squash_next)
        else $error("squash held longer than one cycle");

    cov_decr_skip: cover property (accept && instr_op == decrement_skip_zero_op && operand == 8'h01);
    cov_daa_carry: cover property (accept && instr_op == decimal_adjust_op ##1 st_reg.c);
    cov_wdt_prescaler: cover property (accept && instr_op == watchdog_clear_op && st_reg.ps_wdt);
    cov_compare_equal: cover property (
        accept && instr_op == compare_acc_register_op && operand == st_reg.accumulator);
    cov_decr_to_acc: cover property (accept && instr_op == decrement_skip_zero_op && !instr_dest);
endmodule // file_register_alu_ops

// *** src/alu_ops_cfg.svh ***
`ifndef ALU_OPS_CFG_SVH
`define ALU_OPS_CFG_SVH
// Summary of operation
// - clear writes 00h to the register and sets zero flag, one cycle
// - complement inverts every register bit and updates zero flag, one cycle
// - complement destination bit 0 goes to accumulator, 1 back to register
// - watchdog clear zeroes counter, and prescaler only when assigned to watchdog
// - watchdog clear sets time-out and power-down status bits to 1
// - compare subtracts accumulator from register, updates zero and carry, one cycle
// - compare discards result; accumulator and register stay unchanged
// - decimal adjust converts accumulator to packed decimal, updates only carry
// - decrement subtracts one; destination bit 0 to accumulator, 1 to register
// - decrement result zero squashes the fetched instruction; two cycles

// ---------------------------------------------------------------
// register map (byte addresses on the wishbone bus)
// ---------------------------------------------------------------
`define ACC_OFS 12'h000
`define STATUS_OFS 12'h004
`define FILE_BASE_HI 3'h1
`define ADR_HI_MSB 11
`define ADR_HI_LSB 9

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define ST_Z_BIT 0
`define ST_C_BIT 1
`define ST_DC_BIT 2
`define ST_PD_BIT 3
`define ST_TO_BIT 4
`define ST_PSW_BIT 5

// ---------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------
`define ACC_RST 8'h00
`define FILE_RST 8'h00
`define TO_N_RST 1'b1
`define PD_N_RST 1'b1
`define PS_WDT_RST 1'b0
`define NIBBLE_MAX 4'h9
`define LO_FIX 9'h006
`define HI_FIX 9'h060
`endif

// *** src/alu_ops_pkg.sv ***
package alu_ops_pkg;
    typedef enum logic [2:0] {
        nop_op = 3'h0,
        clear_register_op = 3'h1,
        complement_register_op = 3'h2,
        watchdog_clear_op = 3'h3,
        compare_acc_register_op = 3'h4,
        decimal_adjust_op = 3'h5,
        decrement_skip_zero_op = 3'h6
    } op_t;

    // gray path: exec -> squash -> exec
    typedef enum logic [1:0] {
        seq_exec = 2'b00,
        seq_squash = 2'b01
    } seq_t;
endpackage

// *** src/alu_calc_if.sv ***
`timescale 1ns/10ps
interface alu_calc_if;
    import alu_ops_pkg::*;
    op_t op;
    logic [7:0] operand;
    logic [7:0] acc;
    logic c_in;
    logic dc_in;
    logic [7:0] result;
    logic z_out;
    logic z_upd;
    logic c_out;
    logic c_upd;
    logic skip;

    modport calc (input op, operand, acc, c_in, dc_in, output result, z_out, z_upd, c_out, c_upd, skip);
    modport core (output op, operand, acc, c_in, dc_in, input result, z_out, z_upd, c_out, c_upd, skip);
endinterface

// *** src/alu_calc.sv ***
`timescale 1ns/10ps
`include "alu_ops_cfg.svh"
module alu_calc
    import alu_ops_pkg::*;
(
    alu_calc_if.calc bus
);
    logic [8:0] diff;
    logic [8:0] lo_sum;
    logic [8:0] hi_sum;
    logic lo_fix;
    logic hi_fix;

    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    assign diff = {1'b0, bus.operand} - {1'b0, bus.acc};
    assign lo_fix = bus.dc_in || (bus.acc[3:0] > `NIBBLE_MAX);
    assign lo_sum = {1'b0, bus.acc} + (lo_fix ? `LO_FIX : 9'h000);
    assign hi_fix = bus.c_in || lo_sum[8] || (lo_sum[7:4] > `NIBBLE_MAX);
    assign hi_sum = lo_sum + (hi_fix ? `HI_FIX : 9'h000);

    always_comb begin
        bus.result = 8'h00;
        bus.z_out = 1'b0;
        bus.z_upd = 1'b0;
        bus.c_out = 1'b0;
        bus.c_upd = 1'b0;
        bus.skip = 1'b0;
        case (bus.op)
            clear_register_op: begin
                bus.result = 8'h00;
                bus.z_out = 1'b1;
                bus.z_upd = 1'b1;
            end
            complement_register_op: begin
                bus.result = ~bus.operand;
                bus.z_out = is_zero(~bus.operand);
                bus.z_upd = 1'b1;
            end
            compare_acc_register_op: begin
                bus.z_out = is_zero(diff[7:0]);
                bus.z_upd = 1'b1;
                bus.c_out = ~diff[8];
                bus.c_upd = 1'b1;
            end
            decimal_adjust_op: begin
                bus.result = hi_sum[7:0];
                bus.c_out = hi_fix;
                bus.c_upd = 1'b1;
            end
            decrement_skip_zero_op: begin
                bus.result = bus.operand - 8'h01;
                bus.skip = is_zero(bus.operand - 8'h01);
            end
            default: begin
                bus.result = 8'h00;
            end
        endcase
    end
endmodule // alu_calc

// *** test/file_register_alu_ops_test.sv ***
`timescale 1ns/10ps
module file_register_alu_ops_test;
    import alu_ops_pkg::*;
    logic core_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [11:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, seed;
    logic instr_valid, instr_dest, instr_ready, took;
    op_t instr_op;
    logic [6:0] instr_addr;
    logic timeout_event, sleep_event, squash_next, watchdog_clear, prescaler_clear;
    int errors, total_checks;
    logic [31:0] rd_q[$];
    logic [3:0] ev_q[$];
    logic [7:0] m_acc;
    logic [7:0] m_file[128];
    logic m_z, m_c, m_dc, m_ps, m_to, m_pd;
    logic [15:0] cmp_tab[4] = '{16'h3412, 16'h1234, 16'h5555, 16'h00ff};
    logic [18:0] daa_tab[4] = '{{8'h4d, 2'b00, 8'h53, 1'b0}, {8'h00, 2'b10, 8'h06, 1'b0},
                                {8'ha0, 2'b00, 8'h00, 1'b1}, {8'h99, 2'b00, 8'h99, 1'b0}};

    file_register_alu_ops file_register_alu_ops_inst (.core_clk(core_clk), .rstn(rstn),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .instr_valid(instr_valid), .instr_op(instr_op), .instr_dest(instr_dest),
        .instr_addr(instr_addr), .instr_ready(instr_ready), .timeout_event(timeout_event),
        .sleep_event(sleep_event), .squash_next(squash_next), .watchdog_clear(watchdog_clear),
        .prescaler_clear(prescaler_clear));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] rnd8();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction

    function automatic logic [11:0] fa(input logic [6:0] n);
        return {3'h1, n, 2'b00};
    endfunction

    function automatic logic [31:0] st();
        return {26'h0, m_ps, m_to, m_pd, m_dc, m_c, m_z};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one classic cycle; the slave's latency is not assumed
    task automatic bus(input logic we, input logic [11:0] adr, input logic [7:0] dat);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, dat};
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            $display("BAD bus ack expected 1 seen 0");
            final_report();
        end else begin
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge core_clk);
        end
    endtask

    task automatic rd(input logic [11:0] adr, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, adr, 8'h00);
    endtask

    task automatic verify(input logic [6:0] n);
        rd(12'h000, {24'h0, m_acc});
        rd(12'h004, st());
        rd(fa(n), {24'h0, m_file[n]});
    endtask

    // f is {prescaler to watchdog, nibble carry, carry, zero}
    task automatic prep(input logic [6:0] n, input logic [7:0] fv, input logic [7:0] av, input logic [3:0] f);
        m_file[n] = fv;
        m_acc = av;
        {m_ps, m_dc, m_c, m_z} = f;
        bus(1'b1, fa(n), fv);
        bus(1'b1, 12'h000, av);
        bus(1'b1, 12'h004, {2'b00, f[3], 2'b00, f[2:0]});
    endtask

    // ev is {ready, squash, watchdog clear, prescaler clear} one cycle after taking;
    // valid is left high so a following call issues back to back
    task automatic exec(input op_t op, input logic d, input logic [6:0] n, input logic [3:0] ev);
        int k;
        ev_q.push_back(ev);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_dest <= d;
        instr_addr <= n;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (instr_ready === 1'b1) break;
        end
        if (k == 20) begin
            errors++;
            $display("BAD instr_ready expected 1 seen 0");
            final_report();
        end
    endtask

    task automatic idle();
        instr_valid <= 1'b0;
        @(posedge core_clk);
    endtask

    // ---------------------------------------------------------------
    // result watcher
    // ---------------------------------------------------------------
    always @(posedge core_clk) begin
        if (took)
            check("instr events", {28'h0, instr_ready, squash_next, watchdog_clear, prescaler_clear}, {28'h0, ev_q.pop_front()});
        took <= instr_valid & instr_ready & rstn;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            check("read data", wb_dat_o, rd_q.pop_front());
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        int i;
        logic [7:0] r, v;
        logic [6:0] n;
        logic s;
        {rstn, wb_cyc_i, wb_stb_i, wb_we_i, instr_valid, instr_dest} = '0;
        {timeout_event, sleep_event} = '0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        instr_op = nop_op;
        instr_addr = 7'h00;
        seed = 32'h34e77dc6;
        {m_acc, m_z, m_c, m_dc, m_ps, m_to, m_pd} = {8'h00, 4'h0, 2'b11};
        for (i = 0; i < 128; i++)
            m_file[i] = 8'h00;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        verify(7'd127);
        bus(1'b1, 12'h100, 8'h5a);
        rd(12'h100, 32'h0);
        prep(7'd127, rnd8() | 8'h01, rnd8(), 4'h0);
        exec(clear_register_op, 1'b0, 7'd127, 4'b1000);
        idle();
        m_file[127] = 8'h00;
        m_z = 1'b1;
        verify(7'd127);
        for (i = 0; i < 2; i++) begin
            v = (i == 0) ? 8'hff : rnd8();
            n = 7'(5 + i);
            prep(n, v, rnd8(), {3'b000, i[0]});
            exec(complement_register_op, i[0], n, 4'b1000);
            idle();
            if (i == 0)
                m_acc = ~v;
            else
                m_file[n] = ~v;
            m_z = (v == 8'hff);
            verify(n);
        end
        for (i = 0; i < 2; i++) begin
            timeout_event <= 1'b1;
            sleep_event <= 1'b1;
            @(posedge core_clk);
            timeout_event <= 1'b0;
            sleep_event <= 1'b0;
            {m_to, m_pd} = 2'b00;
            prep(7'd9, rnd8(), rnd8(), {i[0], 3'b000});
            rd(12'h004, st());
            exec(watchdog_clear_op, 1'b0, 7'd0, {3'b101, i[0]});
            idle();
            {m_to, m_pd} = 2'b11;
            verify(7'd9);
        end
        for (i = 0; i < 5; i++) begin
            if (i < 4)
                {r, v} = cmp_tab[i];
            else
                {r, v} = {rnd8(), rnd8()};
            n = 7'(20 + i);
            prep(n, r, v, i[0] ? 4'h3 : 4'h0);
            exec(compare_acc_register_op, 1'b0, n, 4'b1000);
            idle();
            m_z = (r == v);
            m_c = (r >= v);
            verify(n);
        end
        for (i = 0; i < 4; i++) begin
            prep(7'd30, rnd8(), daa_tab[i][18:11], {1'b0, daa_tab[i][10:9], 1'b1});
            exec(decimal_adjust_op, 1'b0, 7'd0, 4'b1000);
            idle();
            m_acc = daa_tab[i][8:1];
            m_c = daa_tab[i][0];
            verify(7'd30);
        end
        for (i = 0; i < 4; i++) begin
            r = (i < 2) ? 8'h01 : ((i == 2) ? 8'h00 : (rnd8() | 8'h02));
            n = 7'(40 + i);
            prep(n, r, rnd8(), {3'b000, i[0]});
            v = r - 8'h01;
            s = (v == 8'h00);
            // a skip must leave one dead cycle before the next instruction
            exec(decrement_skip_zero_op, ~i[0], n, {~s, s, 2'b00});
            exec(clear_register_op, 1'b0, 7'd50, 4'b1000);
            idle();
            if (i[0])
                m_acc = v;
            else
                m_file[n] = v;
            m_z = 1'b1;
            verify(n);
        end
        final_report();
    end
endmodule // file_register_alu_ops_test
